// ### src/lrs_pkg.sv
// Shared constants, types and helper functions of the display RAM load and scan block.
package lrs_pkg;

  // Display RAM geometry.
  localparam int          RAM_WORDS   = 80;
  localparam int          RAM_BITS    = 4;
  localparam logic [6:0]  PTR_LAST    = 7'h4f;
  localparam logic [6:0]  PTR_RESET   = 7'h00;
  localparam logic [2:0]  SUB_RESET   = 3'h0;
  localparam logic [2:0]  BYTE_LAST   = 3'h7;
  localparam logic [1:0]  BANK_OFFSET = 2'h2;

  // Frame timing: one frame lasts FRAME_DIV ticks of the display clock.
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          FRAME_HZ      = 64;
  localparam int          FRAME_DIV     = 24;
  localparam int          OSC_TICK_CYC  = CLK_HZ / (FRAME_HZ * FRAME_DIV);
  localparam int          HOST_HALF_CYC = CLK_HZ / (FRAME_HZ * FRAME_DIV * 2);
  localparam logic [4:0]  TICKS_STATIC  = 5'h18;
  localparam logic [4:0]  TICKS_MUX2    = 5'h0c;
  localparam logic [4:0]  TICKS_MUX3    = 5'h08;
  localparam logic [4:0]  TICKS_MUX4    = 5'h06;

  // Pin vector positions inside the device synchroniser.
  localparam int          PIN_CLK  = 0;
  localparam int          PIN_OSC  = 1;
  localparam int          PIN_SYNC = 2;
  localparam int          PIN_SUB  = 3;
  localparam int          PIN_W    = 6;

  // Command argument field positions.
  localparam int          ARG_MODE_LSB = 0;
  localparam int          ARG_DISP_EN  = 3;
  localparam int          ARG_OUT_BANK = 0;
  localparam int          ARG_IN_BANK  = 1;

  // Host register offsets.
  localparam logic [1:0]  REG_CMD    = 2'h0;
  localparam logic [1:0]  REG_DATA   = 2'h1;
  localparam logic [1:0]  REG_STATUS = 2'h2;
  localparam logic [1:0]  REG_ABORT  = 2'h3;
  localparam int          CMD_OP_LSB = 8;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_RELOAD  = 1;

  // Drive modes; the code of each is what the mode set command carries.
  typedef enum logic [1:0] {
    LRS_MUX4   = 2'h0,
    LRS_STATIC = 2'h1,
    LRS_MUX2   = 2'h2,
    LRS_MUX3   = 2'h3
  } lrs_mode_e;

  // Commands passed across the link once acknowledged.
  typedef enum logic [2:0] {
    LRS_OP_NONE     = 3'h0,
    LRS_OP_MODE     = 3'h1,
    LRS_OP_LOAD_PTR = 3'h2,
    LRS_OP_DEV_SEL  = 3'h3,
    LRS_OP_BANK     = 3'h4
  } lrs_op_e;

  // Highest RAM bit used by a mode; also the scan start point after sync.
  function automatic logic [1:0] lrs_last_row(input lrs_mode_e m);
    case (m)
      LRS_STATIC: lrs_last_row = 2'h0;
      LRS_MUX2:   lrs_last_row = 2'h1;
      LRS_MUX3:   lrs_last_row = 2'h2;
      default:    lrs_last_row = 2'h3;
    endcase
  endfunction : lrs_last_row

  // Display clock ticks spent on each multiplex phase.
  function automatic logic [4:0] lrs_phase_ticks(input lrs_mode_e m);
    case (m)
      LRS_STATIC: lrs_phase_ticks = TICKS_STATIC;
      LRS_MUX2:   lrs_phase_ticks = TICKS_MUX2;
      LRS_MUX3:   lrs_phase_ticks = TICKS_MUX3;
      default:    lrs_phase_ticks = TICKS_MUX4;
    endcase
  endfunction : lrs_phase_ticks

  // Multiplex phase carried by backplane output k in mode m.
  function automatic logic [1:0] lrs_bp_row(input logic [1:0] k, input lrs_mode_e m);
    case (m)
      LRS_STATIC: lrs_bp_row = 2'h0;
      LRS_MUX2:   lrs_bp_row = {1'b0, k[0]};
      LRS_MUX3:   lrs_bp_row = (k == 2'h3) ? 2'h1 : k;
      default:    lrs_bp_row = k;
    endcase
  endfunction : lrs_bp_row

endpackage : lrs_pkg

// ### src/lrs_if.sv
// Link between the host controller and the display driver.
`timescale 1ns/1ps
interface lrs_if;
  logic       bit_valid;
  logic       bit_data;
  logic       cmd_valid;
  logic [2:0] cmd_op;
  logic [7:0] cmd_arg;
  logic       xfer_abort;
  logic       ack;
  logic       host_clk;
  logic       dev_clk_o;
  logic       dev_clk_oe_n;
  logic       clk_pad;

  // The clock pad carries the device clock when it drives, else the host feed.
  assign clk_pad = dev_clk_oe_n ? host_clk : dev_clk_o;

  modport dev  (input bit_valid, bit_data, cmd_valid, cmd_op, cmd_arg, xfer_abort, clk_pad,
                output ack, dev_clk_o, dev_clk_oe_n);
  modport host (output bit_valid, bit_data, cmd_valid, cmd_op, cmd_arg, xfer_abort, host_clk,
                input ack);
endinterface : lrs_if

// ### src/lrs_dev.sv
// Display driver end: RAM load, pointer, subaddress gating, frame timing and scan.
//
// Summary of operation
// - Select pin low: internal clock driven out.
// - Select pin high: clock pad is input.
// - Frame is clock divided by 24.
// - Sync restarts scan at last mode row.
// - Latch holds one RAM column per phase.
// - Eighty segment outputs follow latch and phase.
// - Backplanes duplicate per mode pairing.
// - One means on; bit picks backplane.
// - Bits stored on arrival; commands after ack.
// - Byte fills 8, 4 or 2 addresses.
// - Mux3 byte fills three addresses, one bit spare.
// - Host loads pointer before display bytes.
// - Pointer advances 8, 4, 3 or 2.
// - Host reloads pointer after cut transfer.
// - Store only when subaddress matches; pointer moves.
// - Subaddress loaded by command, bumped on wrap.
// - Scan steps through the mode's RAM bits.
// - Output bank swaps in bits 2 and 3 in static and mux2 only.
// - Input bank writes into bits 2 and 3 in static and mux2 only.
// - Host idles data line high after power-up.
// - Clock into device never stops.
// - Reset: mux4, display off, banks, pointer cleared.
// - Input and output banks independent.
`timescale 1ns/1ps
module lrs_dev #(
  parameter int OSC_TICK_CYCLES = lrs_pkg::OSC_TICK_CYC
) (
  // Clock, reset and enable.
  input  wire logic         MCLK,
  input  wire logic         RESET_N,
  input  wire logic         CE,
  // Straps and cascade pins.
  input  wire logic         CLOCK_SOURCE_SELECT_PIN,
  input  wire logic         CASCADE_SYNC_N,
  input  wire logic [2:0]   HARDWARE_SUBADDRESS_INPUTS,
  // Display drive.
  output logic      [79:0]  SEGMENT_OUTPUTS,
  output logic      [3:0]   BACKPLANE_OUTPUTS,
  // Link to the host.
  lrs_if.dev                link
);

  typedef struct packed {
    logic [lrs_pkg::PIN_W-1:0] p1;
    logic [lrs_pkg::PIN_W-1:0] p2;
    logic [lrs_pkg::PIN_W-1:0] p3;
    logic [lrs_pkg::PIN_W-1:0] flt;
    logic                      clk_prev;
    logic                      sync_prev;
    logic [17:0]               osc_cnt;
    logic                      clk_out;
    lrs_pkg::lrs_mode_e        mode;
    logic                      disp_en;
    logic                      in_bank;
    logic                      out_bank;
    logic [6:0]                ptr;
    logic [2:0]                subaddr;
    logic [1:0]                bit_pos;
    logic [2:0]                bit_cnt;
    logic                      ack;
    logic                      cmd_pend;
    lrs_pkg::lrs_op_e          cmd_op;
    logic [7:0]                cmd_arg;
    logic [4:0]                pcnt;
    logic [1:0]                phase;
    logic                      invert;
    logic [79:0]               latch;
    logic [79:0][3:0]          ram;
    logic [79:0]               seg;
    logic [3:0]                bp;
  } lrs_dev_s;

  localparam logic [17:0] OSC_LAST = 18'(OSC_TICK_CYCLES - 1);

  lrs_dev_s r;
  lrs_dev_s n;

  logic                      tick;
  logic                      adv;
  logic                      load;
  logic                      bank_ok;
  logic [1:0]                last_row;
  logic [1:0]                wbit;
  logic [1:0]                col;
  logic [lrs_pkg::PIN_W-1:0] pins;

  // Raw pins packed in the order of the pin positions the synchroniser stages index.
  assign pins = {HARDWARE_SUBADDRESS_INPUTS, CASCADE_SYNC_N, CLOCK_SOURCE_SELECT_PIN, link.clk_pad};

  // Next-state logic for the whole driver.
  always_comb begin
    n        = r;
    tick     = 1'b0;
    adv      = 1'b0;
    load     = 1'b0;
    last_row = lrs_pkg::lrs_last_row(r.mode);
    bank_ok  = (r.mode == lrs_pkg::LRS_STATIC) || (r.mode == lrs_pkg::LRS_MUX2);
    wbit     = r.bit_pos;
    col      = 2'h0;

    // Pin synchroniser; a level counts once the last two stages agree.
    n.p1  = pins;
    n.p2  = r.p1;
    n.p3  = r.p2;
    n.flt = (r.p2 & r.p3) | (r.flt & (r.p2 ^ r.p3));
    n.clk_prev  = r.flt[lrs_pkg::PIN_CLK];
    n.sync_prev = r.flt[lrs_pkg::PIN_SYNC];

    // Display clock source: internal divider or edges seen on the pad.
    if (r.flt[lrs_pkg::PIN_OSC]) begin
      tick = r.flt[lrs_pkg::PIN_CLK] & ~r.clk_prev;
    end else if (r.osc_cnt == OSC_LAST) begin
      n.osc_cnt = 18'h0;
      tick      = 1'b1;
      n.clk_out = ~r.clk_out;
    end else begin
      n.osc_cnt = r.osc_cnt + 18'h1;
    end

    // Display bits go into RAM the moment they arrive.
    n.ack = 1'b0;
    if (link.xfer_abort) begin
      n.bit_cnt = 3'h0;
      n.bit_pos = 2'h0;
    end else if (link.bit_valid) begin
      wbit = r.bit_pos + ((r.in_bank && bank_ok) ? lrs_pkg::BANK_OFFSET : 2'h0);
      if (r.subaddr == r.flt[lrs_pkg::PIN_SUB +: 3]) begin
        n.ram[r.ptr][wbit] = link.bit_data;
      end
      n.bit_cnt = r.bit_cnt + 3'h1;
      // The last bit of a byte closes the address so mux3 leaves its bit 2 alone.
      if ((r.bit_pos == last_row) || (r.bit_cnt == lrs_pkg::BYTE_LAST)) begin
        n.bit_pos = 2'h0;
        adv       = 1'b1;
      end else begin
        n.bit_pos = r.bit_pos + 2'h1;
      end
      n.ack = (r.bit_cnt == lrs_pkg::BYTE_LAST);
    end

    // Pointer wrap carries into the subaddress counter, even mid byte.
    if (adv) begin
      if (r.ptr == lrs_pkg::PTR_LAST) begin
        n.ptr     = lrs_pkg::PTR_RESET;
        n.subaddr = r.subaddr + 3'h1;
      end else begin
        n.ptr = r.ptr + 7'h1;
      end
    end

    // Commands are acknowledged first and applied in the following cycle.
    if (link.cmd_valid) begin
      n.ack      = 1'b1;
      n.cmd_pend = 1'b1;
      n.cmd_op   = lrs_pkg::lrs_op_e'(link.cmd_op);
      n.cmd_arg  = link.cmd_arg;
    end else begin
      n.cmd_pend = 1'b0;
    end
    if (r.cmd_pend) begin
      case (r.cmd_op)
        lrs_pkg::LRS_OP_MODE: begin
          n.mode    = lrs_pkg::lrs_mode_e'(r.cmd_arg[lrs_pkg::ARG_MODE_LSB +: 2]);
          n.disp_en = r.cmd_arg[lrs_pkg::ARG_DISP_EN];
        end
        lrs_pkg::LRS_OP_LOAD_PTR: begin
          n.ptr     = (r.cmd_arg[6:0] > lrs_pkg::PTR_LAST) ? lrs_pkg::PTR_RESET : r.cmd_arg[6:0];
          n.bit_pos = 2'h0;
          n.bit_cnt = 3'h0;
        end
        lrs_pkg::LRS_OP_DEV_SEL: begin
          n.subaddr = r.cmd_arg[2:0];
        end
        lrs_pkg::LRS_OP_BANK: begin
          n.in_bank  = r.cmd_arg[lrs_pkg::ARG_IN_BANK];
          n.out_bank = r.cmd_arg[lrs_pkg::ARG_OUT_BANK];
        end
        default: begin
          n.cmd_pend = n.cmd_pend;
        end
      endcase
    end

    // Scan timing: phases share the 24-tick frame; sync forces the last row.
    if (~r.flt[lrs_pkg::PIN_SYNC] && r.sync_prev) begin
      n.phase = last_row;
      n.pcnt  = 5'h0;
      load    = 1'b1;
    end else if (tick) begin
      // A mode change can leave the count past the new phase length; end the phase at once then.
      if (r.pcnt >= lrs_pkg::lrs_phase_ticks(r.mode) - 5'h1) begin
        n.pcnt = 5'h0;
        load   = 1'b1;
        if (r.phase >= last_row) begin
          n.phase  = 2'h0;
          n.invert = ~r.invert;
        end else begin
          n.phase = r.phase + 2'h1;
        end
      end else begin
        n.pcnt = r.pcnt + 5'h1;
      end
    end

    // Latch one RAM column for the phase about to be driven.
    col = n.phase + ((r.out_bank && bank_ok) ? lrs_pkg::BANK_OFFSET : 2'h0);
    if (load) begin
      for (int i = 0; i < lrs_pkg::RAM_WORDS; i++) begin
        n.latch[i] = r.ram[i][col];
      end
    end

    // Drive levels, inverted each frame so the panel sees no DC.
    n.seg = r.disp_en ? (r.latch ^ {80{r.invert}}) : 80'h0;
    for (int k = 0; k < lrs_pkg::RAM_BITS; k++) begin
      n.bp[k] = r.disp_en & ((lrs_pkg::lrs_bp_row(2'(k), r.mode) == r.phase) ^ r.invert);
    end
  end

  // State register; power-on values select mux4 with the display off.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r          <= '0;
      r.mode     <= lrs_pkg::LRS_MUX4;
      r.ptr      <= lrs_pkg::PTR_RESET;
      r.subaddr  <= lrs_pkg::SUB_RESET;
      r.cmd_op   <= lrs_pkg::LRS_OP_NONE;
      r.flt      <= {lrs_pkg::PIN_W{1'b0}};
    end else if (CE) begin
      r <= n;
    end
  end

  // Outputs.
  assign SEGMENT_OUTPUTS   = r.seg;
  assign BACKPLANE_OUTPUTS = r.bp;
  assign link.ack          = r.ack;
  assign link.dev_clk_o    = r.clk_out;
  assign link.dev_clk_oe_n = r.flt[lrs_pkg::PIN_OSC];

endmodule : lrs_dev

// ### src/lrs_host.sv
// Host end: register port for software, sends each command in one cycle and serialises display bytes.
`timescale 1ns/1ps
module lrs_host #(
  parameter int HOST_HALF_CYCLES = lrs_pkg::HOST_HALF_CYC
) (
  // Clock, reset and enable.
  input  wire logic         MCLK,
  input  wire logic         RESET_N,
  input  wire logic         CE,
  // Software register port.
  input  wire logic [1:0]   ADDR,
  input  wire logic [15:0]  WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output logic      [15:0]  RDATA,
  // Link to the driver.
  lrs_if.host               link
);

  typedef enum logic [1:0] {
    LRS_H_IDLE = 2'h0,
    LRS_H_SEND = 2'h1,
    LRS_H_WAIT = 2'h2
  } lrs_hstate_e;

  typedef struct packed {
    lrs_hstate_e st;
    logic [7:0]  shift;
    logic [2:0]  cnt;
    logic        reload;
    logic        bit_valid;
    logic        bit_data;
    logic        cmd_valid;
    logic [2:0]  cmd_op;
    logic [7:0]  cmd_arg;
    logic        abort;
    logic [17:0] hcnt;
    logic        hclk;
    logic [15:0] rdata;
  } lrs_host_s;

  localparam logic [17:0] HALF_LAST = 18'(HOST_HALF_CYCLES - 1);

  lrs_host_s r;
  lrs_host_s n;

  // Next-state logic: one transfer at a time, software writes while busy are dropped, except an abort while a byte is sent.
  always_comb begin
    n           = r;
    n.bit_valid = 1'b0;
    n.bit_data  = 1'b1;
    n.cmd_valid = 1'b0;
    n.abort     = 1'b0;
    n.rdata     = 16'h0;

    // Free-running clock feed for the pad; it never stops.
    if (r.hcnt == HALF_LAST) begin
      n.hcnt = 18'h0;
      n.hclk = ~r.hclk;
    end else begin
      n.hcnt = r.hcnt + 18'h1;
    end

    if (RD && (ADDR == lrs_pkg::REG_STATUS)) begin
      n.rdata[lrs_pkg::ST_BUSY]   = (r.st != LRS_H_IDLE);
      n.rdata[lrs_pkg::ST_RELOAD] = r.reload;
    end

    case (r.st)
      LRS_H_IDLE: begin
        if (WR && (ADDR == lrs_pkg::REG_CMD)) begin
          n.cmd_valid = 1'b1;
          n.cmd_op    = WDATA[lrs_pkg::CMD_OP_LSB +: 3];
          n.cmd_arg   = WDATA[7:0];
          n.st        = LRS_H_WAIT;
          if (WDATA[lrs_pkg::CMD_OP_LSB +: 3] == lrs_pkg::LRS_OP_LOAD_PTR) begin
            n.reload = 1'b0;
          end
        end else if (WR && (ADDR == lrs_pkg::REG_DATA) && !r.reload) begin
          n.shift = WDATA[7:0];
          n.cnt   = 3'h0;
          n.st    = LRS_H_SEND;
        end
      end
      LRS_H_SEND: begin
        if (WR && (ADDR == lrs_pkg::REG_ABORT)) begin
          n.abort  = 1'b1;
          n.reload = 1'b1;
          n.st     = LRS_H_IDLE;
        end else begin
          n.bit_valid = 1'b1;
          n.bit_data  = r.shift[7];
          n.shift     = {r.shift[6:0], 1'b0};
          n.cnt       = r.cnt + 3'h1;
          if (r.cnt == lrs_pkg::BYTE_LAST) begin
            n.st = LRS_H_WAIT;
          end
        end
      end
      LRS_H_WAIT: begin
        if (link.ack) begin
          n.st = LRS_H_IDLE;
        end
      end
      default: begin
        n.st = LRS_H_IDLE;
      end
    endcase
  end

  // State register; reset demands a pointer load before any display byte.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r          <= '0;
      r.st       <= LRS_H_IDLE;
      r.reload   <= 1'b1;
      r.bit_data <= 1'b1;
    end else if (CE) begin
      r <= n;
    end
  end

  // Outputs.
  assign RDATA           = r.rdata;
  assign link.bit_valid  = r.bit_valid;
  assign link.bit_data   = r.bit_data;
  assign link.cmd_valid  = r.cmd_valid;
  assign link.cmd_op     = r.cmd_op;
  assign link.cmd_arg    = r.cmd_arg;
  assign link.xfer_abort = r.abort;
  assign link.host_clk   = r.hclk;

endmodule : lrs_host

// ### testbench/lrs_assertions.sv
// Concurrent checks on the link that joins the host and display driver ends.
`timescale 1ns/1ps
module lrs_assertions #(
  parameter int OSC_TICK_CYCLES  = lrs_pkg::OSC_TICK_CYC,
  parameter int HOST_HALF_CYCLES = lrs_pkg::HOST_HALF_CYC
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // Link signals.
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic cmd_valid,
  input wire logic xfer_abort,
  input wire logic ack,
  input wire logic host_clk,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe_n
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // Bits of the open byte, and cycles since each clock line last moved.
  // The seen flags skip the first toggle, whose distance from reset is not fixed.
  logic [3:0] nbits_r;
  logic [17:0] osc_r;
  logic [17:0] hclk_r;
  logic       osc_q_r;
  logic       hclk_q_r;
  logic       osc_seen_r;
  logic       hclk_seen_r;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      nbits_r     <= 4'h0;
      osc_r       <= 18'h0;
      hclk_r      <= 18'h0;
      osc_q_r     <= 1'b0;
      hclk_q_r    <= 1'b0;
      osc_seen_r  <= 1'b0;
      hclk_seen_r <= 1'b0;
    end else begin
      nbits_r     <= (xfer_abort || (bit_valid && nbits_r == 4'h7)) ? 4'h0 : nbits_r + 4'(bit_valid);
      osc_r       <= (dev_clk_o != osc_q_r) ? 18'h0 : osc_r + 18'h1;
      hclk_r      <= (host_clk != hclk_q_r) ? 18'h0 : hclk_r + 18'h1;
      osc_q_r     <= dev_clk_o;
      hclk_q_r    <= host_clk;
      osc_seen_r  <= osc_seen_r | (dev_clk_o != osc_q_r);
      hclk_seen_r <= hclk_seen_r | (host_clk != hclk_q_r);
    end
  end

  a_ack_cmd: assert property (cmd_valid |=> ack) else $error("command not acknowledged");
  a_ack_byte: assert property (bit_valid && nbits_r == 4'h7 |=> ack) else $error("byte not acknowledged");
  a_ack_cause: assert property (ack |-> $past(cmd_valid) || $past(bit_valid && nbits_r == 4'h7)) else $error("stray ack");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_byte_burst: assert property ($rose(bit_valid) |-> (bit_valid [*8] ##1 !bit_valid) or (##[0:8] xfer_abort)) else $error("byte not eight bits");
  a_idle_high: assert property ($fell(bit_valid) |-> ##[0:2] bit_data) else $error("data line not idle high");
  a_cmd_single: assert property (cmd_valid |=> !cmd_valid && !bit_valid) else $error("request while command open");
  a_osc_rate: assert property (!dev_clk_oe_n && osc_seen_r && $changed(dev_clk_o) |-> osc_r == 18'(OSC_TICK_CYCLES - 1)) else $error("internal clock rate wrong");
  a_hclk_runs: assert property (hclk_seen_r && $changed(host_clk) |-> hclk_r == 18'(HOST_HALF_CYCLES - 1)) else $error("host clock feed stalled");
endmodule : lrs_assertions

// ### testbench/test_lcd_ram_load_and_mux_scan.sv
// Self-checking bench: host and display driver joined by the link, with a RAM image model.
`timescale 1ns/1ps
module test_lcd_ram_load_and_mux_scan;
  localparam int OSC  = 4;
  localparam int HALF = 3;
  typedef struct packed {logic [2:0] sub; logic [1:0] mode; logic ib; logic [6:0] ptr; logic [7:0] data;} lrs_row_s;
  // Subaddress, mode, input bank, pointer and byte of each ordinary case.
  localparam lrs_row_s ROWS [8] = '{'{3'h1, 2'h0, 1'b0, 7'h29, 8'hff}, '{3'h1, 2'h3, 1'b0, 7'h28, 8'h00},
    '{3'h1, 2'h1, 1'b0, 7'h05, 8'ha5}, '{3'h1, 2'h1, 1'b1, 7'h0d, 8'h3c}, '{3'h1, 2'h2, 1'b0, 7'h32, 8'hc9},
    '{3'h1, 2'h2, 1'b1, 7'h3c, 8'h96}, '{3'h1, 2'h0, 1'b0, 7'h4e, 8'he7}, '{3'h0, 2'h3, 1'b0, 7'h4e, 8'hff}};
  logic        mclk    = 1'b0;
  logic        reset_n = 1'b0;
  logic        sel     = 1'b0;
  logic        sync_n  = 1'b1;
  logic [2:0]  strap   = 3'h1;
  logic [1:0]  addr    = 2'h0;
  logic [15:0] wdata   = 16'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [15:0] rdata;
  logic [79:0] seg;
  logic [3:0]  bp;
  logic [3:0]  ram [80];
  logic [2:0]  sub;
  logic [1:0]  mode_cur;
  logic        ibank;
  int          ptr;
  int          num_errors  = 0;
  int          checks_done = 0;

  lrs_if link ();
  lrs_dev #(.OSC_TICK_CYCLES(OSC)) u_lrs_dev (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
    .CLOCK_SOURCE_SELECT_PIN(sel), .CASCADE_SYNC_N(sync_n), .HARDWARE_SUBADDRESS_INPUTS(strap),
    .SEGMENT_OUTPUTS(seg), .BACKPLANE_OUTPUTS(bp), .link(link));
  lrs_host #(.HOST_HALF_CYCLES(HALF)) u_lrs_host (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .link(link));
  lrs_assertions #(.OSC_TICK_CYCLES(OSC), .HOST_HALF_CYCLES(HALF)) u_lrs_assertions (.MCLK(mclk),
    .RESET_N(reset_n), .bit_valid(link.bit_valid), .bit_data(link.bit_data), .cmd_valid(link.cmd_valid),
    .xfer_abort(link.xfer_abort), .ack(link.ack), .host_clk(link.host_clk), .dev_clk_o(link.dev_clk_o),
    .dev_clk_oe_n(link.dev_clk_oe_n));

  // A 5 ns clock.
  always #2.5 mclk = ~mclk;

  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Register port cycles; read data is taken in the cycle after the strobe only.
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Polls status under a bound; writes made while busy would be dropped.
  task automatic wait_idle();
    logic [15:0] s;
    int n;
    n = 0;
    do begin
      rd_reg(lrs_pkg::REG_STATUS, s);
      n++;
    end while (s[lrs_pkg::ST_BUSY] !== 1'b0 && n < 100);
    chk(80'(s[lrs_pkg::ST_BUSY]), 80'h0);
  endtask : wait_idle

  task automatic cmd(input lrs_pkg::lrs_op_e op, input logic [7:0] arg);
    wr_reg(lrs_pkg::REG_CMD, {5'h0, op, arg});
    wait_idle();
    if (op == lrs_pkg::LRS_OP_MODE) mode_cur = arg[1:0];
  endtask : cmd

  // Sends a byte and mirrors where it must land, bit by bit, in the model.
  task automatic send_byte(input logic [7:0] b);
    int n;
    int off;
    int k;
    n   = (mode_cur == 2'h0) ? 4 : int'(mode_cur);
    off = (n < 3 && ibank) ? 2 : 0;
    k   = 0;
    wr_reg(lrs_pkg::REG_DATA, {8'h0, b});
    wait_idle();
    for (int i = 7; i >= 0; i--) begin
      if (sub == strap) ram[ptr][off + k] = b[i];
      k++;
      if (k == n || i == 0) begin
        k   = 0;
        ptr = (ptr == 79) ? 0 : ptr + 1;
        if (ptr == 0) sub++;
      end
    end
  endtask : send_byte

  function automatic logic [79:0] image(input int k);
    for (int a = 0; a < 80; a++) image[a] = ram[a][k];
  endfunction : image

  // The phase k is driven when its backplane is the odd one out of four; in static mode only phase 0 is driven.
  function automatic logic active(input int k);
    active = (mode_cur == 2'h1) ? (k == 0) : ((bp ^ {4{~bp[k]}}) == (4'h1 << k));
  endfunction : active

  function automatic logic [3:0] dup(input logic [3:0] b, input logic [1:0] m);
    case (m)
      2'h1: dup = {4{b[0]}};
      2'h2: dup = {b[1], b[0], b[1], b[0]};
      2'h3: dup = {b[1], b[2:0]};
      default: dup = b;
    endcase
  endfunction : dup

  // Waits a frame so the latch holds current settings, then decodes column k.
  task automatic read_col(input int k, output logic [79:0] col);
    logic prev;
    int n;
    prev = 1'b0;
    n    = 0;
    repeat (100) @(posedge mclk);
    do begin
      prev = active(k);
      @(posedge mclk);
      #1 n++;
    end while (!(prev && active(k)) && n < 400);
    col = ~(seg ^ {80{bp[k]}});
  endtask : read_col

  // Cycles between two inversions of the static backplane: one frame.
  task automatic frame(input int exp);
    logic b;
    int n;
    for (int j = 0; j < 2; j++) begin
      b = bp[0];
      n = 0;
      do begin
        @(posedge mclk);
        #1 n++;
      end while (bp[0] === b && n < 1000);
    end
    chk(80'(n), 80'(exp));
  endtask : frame

  initial begin
    logic [15:0] s;
    logic [79:0] col;
    foreach (ram[a]) ram[a] = 4'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1 chk(seg, 80'h0);
    chk(80'(bp), 80'h0);
    chk(80'(link.dev_clk_oe_n), 80'h0);
    rd_reg(lrs_pkg::REG_STATUS, s);
    chk(80'(s), 80'h2);
    cmd(lrs_pkg::LRS_OP_DEV_SEL, 8'h01);
    sub = 3'h1;
    cmd(lrs_pkg::LRS_OP_MODE, 8'h08);
    cmd(lrs_pkg::LRS_OP_LOAD_PTR, 8'h00);
    ptr = 0;
    ibank = 1'b0;
    repeat (40) send_byte(8'h00);
    foreach (ROWS[i]) begin
      cmd(lrs_pkg::LRS_OP_DEV_SEL, {5'h0, ROWS[i].sub});
      sub = ROWS[i].sub;
      cmd(lrs_pkg::LRS_OP_MODE, {6'h2, ROWS[i].mode});
      repeat (3) @(posedge mclk);
      #1 chk(80'(bp), 80'(dup(bp, mode_cur)));
      cmd(lrs_pkg::LRS_OP_BANK, {6'h0, ROWS[i].ib, 1'b0});
      ibank = ROWS[i].ib;
      cmd(lrs_pkg::LRS_OP_LOAD_PTR, {1'b0, ROWS[i].ptr});
      ptr = int'(ROWS[i].ptr);
      send_byte(ROWS[i].data);
      send_byte(~ROWS[i].data);
    end
    // A cut byte leaves the host refusing display data until the pointer is reloaded.
    cmd(lrs_pkg::LRS_OP_DEV_SEL, 8'h00);
    wr_reg(lrs_pkg::REG_DATA, 16'h00a5);
    wr_reg(lrs_pkg::REG_ABORT, 16'h0000);
    rd_reg(lrs_pkg::REG_STATUS, s);
    chk(80'(s), 80'h2);
    wr_reg(lrs_pkg::REG_DATA, 16'h00a5);
    rd_reg(lrs_pkg::REG_STATUS, s);
    chk(80'(s), 80'h2);
    cmd(lrs_pkg::LRS_OP_MODE, 8'h08);
    cmd(lrs_pkg::LRS_OP_BANK, 8'h00);
    for (int k = 0; k < 4; k++) begin
      read_col(k, col);
      chk(col, image(k));
    end
    // Sync restarts the scan at the last phase of the mode.
    @(posedge mclk);
    sync_n <= 1'b0;
    repeat (4) @(posedge mclk);
    sync_n <= 1'b1;
    repeat (4) @(posedge mclk);
    repeat (12) begin
      @(posedge mclk);
      #1 chk(80'(active(3)), 80'h1);
    end
    cmd(lrs_pkg::LRS_OP_MODE, 8'h09);
    cmd(lrs_pkg::LRS_OP_BANK, 8'h01);
    read_col(0, col);
    chk(col, image(2));
    cmd(lrs_pkg::LRS_OP_BANK, 8'h00);
    read_col(0, col);
    chk(col, image(0));
    frame(24 * OSC);
    @(posedge mclk);
    sel <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(80'(link.dev_clk_oe_n), 80'h1);
    frame(24 * 2 * HALF);
    stop_test();
  end

  // Watchdog, far beyond the few thousand cycles the tests need.
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule : test_lcd_ram_load_and_mux_scan
